// File: src/tcr_config_regs.v
// Purpose: two 8-bit transceiver configuration registers behind APB
// Assumes: tx_clk_tick pulses once per tx parallel output clock cycle
// Notes: registers at byte address 4 x index; one wait state per transfer;
//        a local status word sits at index 0x06 beside the two config bytes;
//        the fifo flush timing is counted in tx_clk_tick pulses, not pclk
//
// Contract
// - ref freq bit: 0 low pair, reset 1
// - bandwidth bit: 0 wide, 1 narrow
// - dejitter reference: 0 normal, 1 vcxo
// - aux clock bit 1 stops the output
// - self flush on overflow when enabled
// - drain finishes 8 to 10 cycles after
// - flush bit high holds fifo in reset
// - signal detect polarity: 0 low, 1 high
// - filtered loop timing uses recovered clock
// - direct loop timing replaces local reference
// - mute receive data on loss of signal
// - output disable forces data zero asynchronously
// - vcxo lock detector enable bit
// - lock status meaningful only when enabled
`include "tcr_consts.vh"

module tcr_config_regs #(
    parameter ADDR_W = 8,
    parameter DRAIN_TICKS = `TCR_DRAIN_DEF
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tx_clk_tick,
    input wire fifo_overflow,
    input wire [3:0] rx_data_in,
    input wire rx_los_raw,
    input wire ext_signal_detect,
    input wire vcxo_lock_raw,
    output reg ref_freq_select,
    output reg multiplier_bandwidth_select,
    output reg dejitter_ref_select,
    output reg aux_clock_on,
    output reg fifo_reset,
    output reg loop_timing_filtered,
    output reg loop_timing_direct,
    output reg loop_div32,
    output reg loss_of_signal_flag,
    output wire [3:0] rx_parallel_data,
    output reg vcxo_lock_detect_on,
    output reg vcxo_locked
);

    // ****************************************
    // flush state machine codes
    // ****************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HOLD = 3'b010;
    localparam [2:0] ST_DRAIN = 3'b100;

    // ****************************************
    // declarations
    // ****************************************
    reg [7:0] clk_fifo_reg;
    reg [7:0] clk_fifo_next;
    reg [7:0] timing_rx_reg;
    reg [7:0] timing_rx_next;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [3:0] cnt_reg;
    reg [3:0] cnt_next;
    reg ovf_seen_reg;
    reg ovf_seen_next;
    reg ovf_prev_reg;
    reg los_reg;
    reg [31:0] rdata_next;
    reg err_next;
    wire access;
    wire wr_fire;
    wire hit_clk_fifo;
    wire hit_timing_rx;
    wire hit_status;
    wire mapped;
    wire ovf_rise;
    wire sd_active;
    wire [7:0] status_word;
    wire flush_bit;
    wire ovf_clear;
    wire hold_done;
    wire drain_last;
    wire self_flush_go;

    // ****************************************
    // apb decode
    // ****************************************

    // access phase; pready rises one cycle into it, the edge that samples it
    // high is the single edge at which writes land
    assign access = psel & penable;
    assign wr_fire = access & pready & pwrite;

    // only the low address byte is decoded; wider buses alias upward
    assign hit_clk_fifo = (paddr[7:0] == `TCR_ADDR_CLK_FIFO);
    assign hit_timing_rx = (paddr[7:0] == `TCR_ADDR_TIMING_RX);
    assign hit_status = (paddr[7:0] == `TCR_ADDR_STATUS);
    assign mapped = hit_clk_fifo | hit_timing_rx | hit_status;

    // handshake flops: one wait state, error on unmapped addresses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & err_next;
            prdata <= rdata_next;
        end
    end

    // read mux; reserved bits above the byte read as zero
    always @* begin
        rdata_next = prdata;
        err_next = ~mapped;
        if (access & ~pready & ~pwrite) begin
            rdata_next = 32'h0000_0000;
            if (hit_clk_fifo) begin
                rdata_next[7:0] = clk_fifo_reg;
            end else if (hit_timing_rx) begin
                rdata_next[7:0] = timing_rx_reg;
            end else if (hit_status) begin
                rdata_next[7:0] = status_word;
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************

    // reserved bits keep what the host writes, except timing register bit 7, which the mask clears
    always @* begin
        clk_fifo_next = clk_fifo_reg;
        timing_rx_next = timing_rx_reg;
        if (wr_fire & hit_clk_fifo) begin
            clk_fifo_next = pwdata[7:0];
        end
        if (wr_fire & hit_timing_rx) begin
            timing_rx_next = pwdata[7:0] & `TCR_MASK_TIMING_RX;
        end
    end

    // ref freq comes up set, every other bit clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_fifo_reg <= `TCR_RST_CLK_FIFO;
            timing_rx_reg <= `TCR_RST_TIMING_RX;
        end else begin
            clk_fifo_reg <= clk_fifo_next;
            timing_rx_reg <= timing_rx_next;
        end
    end

    // ****************************************
    // clock steering outputs
    // ****************************************

    // registered copies so every pin comes from a flop; one cycle behind
    // the register, which is harmless for static steering
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_freq_select <= 1'b1;
            multiplier_bandwidth_select <= 1'b0;
            dejitter_ref_select <= 1'b0;
            aux_clock_on <= 1'b1;
            loop_timing_filtered <= 1'b0;
            loop_timing_direct <= 1'b0;
            loop_div32 <= 1'b0;
            vcxo_lock_detect_on <= 1'b0;
        end else begin
            ref_freq_select <= clk_fifo_reg[`TCR_B_REF_FREQ];
            multiplier_bandwidth_select <= clk_fifo_reg[`TCR_B_MULT_BW];
            dejitter_ref_select <= clk_fifo_reg[`TCR_B_DJ_REF];
            aux_clock_on <= ~clk_fifo_reg[`TCR_B_AUX_OFF];
            loop_timing_filtered <= timing_rx_reg[`TCR_B_LT_FILT];
            loop_timing_direct <= timing_rx_reg[`TCR_B_LT_DIRECT];
            // low reference pair needs the deeper divide of the recovered clock;
            // the high pair takes the divide by 16
            loop_div32 <= timing_rx_reg[`TCR_B_LT_DIRECT] & ~clk_fifo_reg[`TCR_B_REF_FREQ];
            vcxo_lock_detect_on <= timing_rx_reg[`TCR_B_VCXO_LKEN];
        end
    end

    // ****************************************
    // fifo flush control
    // ****************************************
    assign flush_bit = clk_fifo_reg[`TCR_B_FIFO_FLUSH];
    assign ovf_rise = fifo_overflow & ~ovf_prev_reg;

    // ****************************************
    // flush conditions
    // ****************************************

    // the hold minimum is counted here, so a host that lets go of the bit
    // too early still gets two full tx cycles of fifo reset
    assign hold_done = (cnt_reg >= `TCR_HOLD_MIN);

    // last drain tick; the count starts from zero on entry to the drain,
    // so exactly DRAIN_TICKS ticks pass before the fifo is let go
    assign drain_last = tx_clk_tick & ({28'h0000000, cnt_reg} == DRAIN_TICKS - 1);

    // an overflow starts a flush by itself only when the host allows it
    assign self_flush_go = ovf_rise & clk_fifo_reg[`TCR_B_SELF_FLUSH];

    // hold: in reset while the bit is set, at least two tx ticks even if the
    // host lets go early; drain: counts tx ticks after release
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = 4'h0;
                if (flush_bit) begin
                    state_next = ST_HOLD;
                end else if (self_flush_go) begin
                    state_next = ST_DRAIN;
                end
            end
            ST_HOLD: begin
                if (tx_clk_tick && !hold_done) begin
                    cnt_next = cnt_reg + 4'h1;
                end
                if (!flush_bit && hold_done) begin
                    state_next = ST_DRAIN;
                    cnt_next = 4'h0;
                end
            end
            ST_DRAIN: begin
                if (flush_bit) begin
                    state_next = ST_HOLD;
                    cnt_next = 4'h0;
                end else if (drain_last) begin
                    state_next = ST_IDLE;
                    cnt_next = 4'h0;
                end else if (tx_clk_tick) begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = 4'h0;
            end
        endcase
    end

    // state, counter and the fifo reset pin; the pin is decoded from the
    // next state so that it comes from a flop and still moves with the state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            fifo_reset <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            fifo_reset <= (state_next != ST_IDLE);
        end
    end

    // ****************************************
    // overflow record
    // ****************************************

    // write one to clear; a new overflow in the same cycle wins, and a
    // manual flush also clears it since that is the recovery path
    assign ovf_clear = (wr_fire & hit_status & pwdata[`TCR_B_ST_OVF]) | (state_reg == ST_HOLD);
    always @* begin
        ovf_seen_next = ovf_seen_reg;
        if (ovf_clear) begin
            ovf_seen_next = 1'b0;
        end
        if (ovf_rise) begin
            ovf_seen_next = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_seen_reg <= 1'b0;
            ovf_prev_reg <= 1'b0;
        end else begin
            ovf_seen_reg <= ovf_seen_next;
            ovf_prev_reg <= fifo_overflow;
        end
    end

    // ****************************************
    // signal detect, loss of signal, lock status
    // ****************************************

    // polarity bit picks which level of the external detect means present
    assign sd_active = timing_rx_reg[`TCR_B_SD_POL] ? ext_signal_detect : ~ext_signal_detect;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_reg <= 1'b0;
            loss_of_signal_flag <= 1'b0;
            vcxo_locked <= 1'b0;
        end else begin
            los_reg <= rx_los_raw | ~sd_active;
            loss_of_signal_flag <= rx_los_raw | ~sd_active;
            // lock reads zero while the detector is off
            vcxo_locked <= vcxo_lock_raw & timing_rx_reg[`TCR_B_VCXO_LKEN];
        end
    end

    // status bits: 0 fifo in reset, 1 overflow seen, 2 loss of signal,
    // 3 vcxo locked, 4 draining; the upper three read as zero
    assign status_word = {3'b000, (state_reg == ST_DRAIN), vcxo_locked, los_reg,
                          ovf_seen_reg, fifo_reset};

    // ****************************************
    // receive data output stage
    // ****************************************

    // mute is clocked; disable clears at once through the stage's clear
    // the disable must not wait for pclk, so it rides on the flops' clear
    // rather than on their data input
    tcr_rx_gate #(
        .W(4)
    ) u_rx_gate (
        .pclk(pclk),
        .presetn(presetn),
        .force_off(timing_rx_reg[`TCR_B_RX_OFF]),
        .mute(timing_rx_reg[`TCR_B_MUTE_LOS] & los_reg),
        .din(rx_data_in),
        .dout(rx_parallel_data)
    );

endmodule

// File: src/tcr_consts.vh
// Purpose: constants for the transceiver configuration register block
// Assumes: 32-bit APB, one register per aligned word, byte address = 4 x index
// Notes: definitions only
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define TCR_IDX_CLK_FIFO 8'h03
`define TCR_IDX_TIMING_RX 8'h04
`define TCR_IDX_STATUS 8'h06
`define TCR_ADDR_CLK_FIFO 8'h0c
`define TCR_ADDR_TIMING_RX 8'h10
`define TCR_ADDR_STATUS 8'h18

// ****************************************
// clock_and_fifo_config fields
// ****************************************
`define TCR_B_REF_FREQ 6
`define TCR_B_MULT_BW 4
`define TCR_B_DJ_REF 3
`define TCR_B_AUX_OFF 2
`define TCR_B_SELF_FLUSH 1
`define TCR_B_FIFO_FLUSH 0
`define TCR_RST_CLK_FIFO 8'h40

// ****************************************
// timing_and_rx_output_config fields
// ****************************************
`define TCR_B_SD_POL 6
`define TCR_B_LT_FILT 5
`define TCR_B_LT_DIRECT 4
`define TCR_B_MUTE_LOS 3
`define TCR_B_RX_OFF 2
`define TCR_B_VCXO_LKEN 0
`define TCR_RST_TIMING_RX 8'h00
`define TCR_MASK_TIMING_RX 8'h7f

// ****************************************
// status fields
// ****************************************
`define TCR_B_ST_FLUSH 0
`define TCR_B_ST_OVF 1
`define TCR_B_ST_LOS 2
`define TCR_B_ST_VCXO 3
`define TCR_B_ST_DRAIN 4

// ****************************************
// flush timing in tx parallel clock cycles
// ****************************************
`define TCR_HOLD_MIN 2
`define TCR_DRAIN_MIN 8
`define TCR_DRAIN_MAX 10
`define TCR_DRAIN_DEF 9

`endif

// File: src/tcr_rx_gate.v
// Purpose: receive parallel data output stage with mute and forced-off clear
// Assumes: din synchronous to pclk
// Notes: force_off clears the outputs without waiting for a clock edge
module tcr_rx_gate #(
    parameter W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire force_off,
    input wire mute,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

    // ****************************************
    // output flops
    // ****************************************

    // the clear is a combination of reset and a register bit; the bit is
    // itself a flop output, so it carries no decode glitches
    wire clr_n;
    assign clr_n = presetn & ~force_off;

    // asynchronous force to zero, synchronous mute to zero
    always @(posedge pclk or negedge clr_n) begin
        if (!clr_n) begin
            dout <= {W{1'b0}};
        end else if (mute) begin
            dout <= {W{1'b0}};
        end else begin
            dout <= din;
        end
    end

endmodule

// File: verification/tcr_cfg_assertions.sv
// Purpose: concurrent checks on the config register block ports
// Assumes: one wait state per apb transfer, outputs one cycle after a write lands
// Notes: bound to the design from the testbench top file
`include "tcr_consts.vh"
module tcr_cfg_assertions #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rx_los_raw,
    input wire ref_freq_select,
    input wire aux_clock_on,
    input wire fifo_reset,
    input wire loss_of_signal_flag,
    input wire [3:0] rx_parallel_data,
    input wire vcxo_lock_detect_on,
    input wire vcxo_locked
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded map, status word included
    wire mapped = paddr == `TCR_ADDR_CLK_FIFO || paddr == `TCR_ADDR_TIMING_RX || paddr == `TCR_ADDR_STATUS;
    wire wr_done = psel && penable && pready && pwrite;
    one_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready not after one wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    unmapped_err_a: assert property (pready |-> pslverr == !mapped) else $error("pslverr does not match decode");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    cfg_follow_a: assert property (wr_done && paddr == `TCR_ADDR_CLK_FIFO |-> ##2
        (ref_freq_select == $past(pwdata[6], 2) && aux_clock_on == !$past(pwdata[2], 2))) else $error("clock outputs stale");
    rx_force_off_a: assert property (wr_done && paddr == `TCR_ADDR_TIMING_RX && pwdata[2] |->
        ##[1:2] rx_parallel_data == 4'h0) else $error("rx data not cleared");
    los_flag_a: assert property ($past(presetn) && $past(rx_los_raw) |-> loss_of_signal_flag) else $error("los flag missed");
    lock_gate_a: assert property (vcxo_locked |-> vcxo_lock_detect_on) else $error("lock shown while disabled");
    flush_hold_a: assert property (wr_done && paddr == `TCR_ADDR_CLK_FIFO && pwdata[0] |->
        ##[1:4] fifo_reset) else $error("fifo not held in reset");
    cover property (pready && pslverr);
    cover property ($fell(fifo_reset));
    cover property (wr_done && paddr == `TCR_ADDR_TIMING_RX && pwdata[2]);
endmodule

// File: verification/testbench.sv
// Purpose: self-checking bench for the config register block
// Assumes: apb master by non-blocking drives, tx tick every 4 pclk
// Notes: read results go through a queue checked by a monitor process
`include "tcr_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    reg pclk, presetn, psel, penable, pwrite, tx_clk_tick, fifo_overflow, rx_los_raw, ext_signal_detect, vcxo_lock_raw;
    reg [7:0] paddr;
    reg [31:0] pwdata, d;
    reg [3:0] rx_data_in;
    reg [7:0] cf;
    reg [32:0] note;
    reg quiet;
    reg [1:0] tcnt;
    wire [31:0] prdata;
    wire [3:0] rx_parallel_data;
    wire pready, pslverr, ref_freq_select, multiplier_bandwidth_select, dejitter_ref_select, aux_clock_on;
    wire fifo_reset, loop_timing_filtered, loop_timing_direct, loss_of_signal_flag, vcxo_lock_detect_on, vcxo_locked;
    wire loop_div32;
    integer seed = 64, fails = 0, n_compared = 0, cyc = 0, n, k;
    reg [32:0] expq[$];
    tcr_config_regs i_tcr_config_regs(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_clk_tick, .fifo_overflow, .rx_data_in, .rx_los_raw, .ext_signal_detect, .vcxo_lock_raw,
        .ref_freq_select, .multiplier_bandwidth_select, .dejitter_ref_select, .aux_clock_on, .fifo_reset,
        .loop_timing_filtered, .loop_timing_direct, .loop_div32, .loss_of_signal_flag, .rx_parallel_data,
        .vcxo_lock_detect_on, .vcxo_locked);
    // ****************************************
    // clock, free inputs, timeout
    // ****************************************
    always #4 pclk = ~pclk;
    // random side inputs keep the gating logic busy
    always @(posedge pclk) begin
        rx_data_in <= $random(seed);
        // quiet pins the detect input low so loss of signal is predictable
        ext_signal_detect <= quiet ? 1'b0 : $random(seed);
        vcxo_lock_raw <= $random(seed);
        tcnt <= tcnt + 2'd1;
        tx_clk_tick <= tcnt == 2'd3;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input w, input [7:0] a, input [31:0] dat);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e, input err);
        expq.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask
    // monitor takes the oldest note when read data appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            note = expq.pop_front();
            chk("prdata", note[31:0], prdata);
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        tcnt = 0;
        quiet = 0;
        tx_clk_tick = 0;
        fifo_overflow = 0;
        rx_los_raw = 0;
        ext_signal_detect = 0;
        vcxo_lock_raw = 0;
        rx_data_in = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TCR_ADDR_CLK_FIFO, `TCR_RST_CLK_FIFO, 0);
        rd(`TCR_ADDR_TIMING_RX, 32'h0, 0);
        chk("aux_on", 1, aux_clock_on);
        $display("reset test done");
        for (k = 0; k < 6; k = k + 1) begin
            d = $random(seed) & 32'hffff_fffc;
            cf = d[7:0];
            apb(1'b1, `TCR_ADDR_CLK_FIFO, d);
            repeat (3) @(posedge pclk);
            chk("ref_freq", d[6], ref_freq_select);
            chk("bandwidth", d[4], multiplier_bandwidth_select);
            chk("dj_ref", d[3], dejitter_ref_select);
            chk("aux_on", !d[2], aux_clock_on);
            rd(`TCR_ADDR_CLK_FIFO, d[7:0], 0);
            d = $random(seed);
            apb(1'b1, `TCR_ADDR_TIMING_RX, d);
            repeat (3) @(posedge pclk);
            chk("lt_filt", d[5], loop_timing_filtered);
            chk("lt_direct", d[4], loop_timing_direct);
            chk("lock_on", d[0], vcxo_lock_detect_on);
            chk("div32", d[4] & ~cf[6], loop_div32);
            if (!d[0]) chk("locked_off", 0, vcxo_locked);
            if (d[2]) chk("rx_off", 0, rx_parallel_data);
            rd(`TCR_ADDR_TIMING_RX, d[7:0] & `TCR_MASK_TIMING_RX, 0);
        end
        apb(1'b1, 8'h14, 32'hff);
        rd(8'h14, 32'h0, 1);
        $display("register test done");
        quiet <= 1'b1;
        apb(1'b1, `TCR_ADDR_TIMING_RX, 32'h48);
        repeat (3) @(posedge pclk);
        chk("los_active_high", 1, loss_of_signal_flag);
        chk("muted_sd", 0, rx_parallel_data);
        apb(1'b1, `TCR_ADDR_TIMING_RX, 32'h08);
        repeat (3) @(posedge pclk);
        chk("los_active_low", 0, loss_of_signal_flag);
        rx_los_raw <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("muted", 0, rx_parallel_data);
        rx_los_raw <= 1'b0;
        apb(1'b1, `TCR_ADDR_CLK_FIFO, 32'h41);
        repeat (3) @(posedge pclk);
        chk("fifo_reset", 1, fifo_reset);
        repeat (12) @(posedge pclk);
        apb(1'b1, `TCR_ADDR_CLK_FIFO, 32'h40);
        n = 0;
        for (k = 0; k < 200 && fifo_reset; k = k + 1) begin
            @(posedge pclk);
            if (tx_clk_tick) n = n + 1;
        end
        chk("drain_in_range", 1, n >= `TCR_DRAIN_MIN && n <= `TCR_DRAIN_MAX);
        apb(1'b1, `TCR_ADDR_CLK_FIFO, 32'h40);
        fifo_overflow <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("no_self_flush", 0, fifo_reset);
        fifo_overflow <= 1'b0;
        rd(`TCR_ADDR_STATUS, 32'h02, 0);
        apb(1'b1, `TCR_ADDR_STATUS, 32'h02);
        rd(`TCR_ADDR_STATUS, 32'h0, 0);
        apb(1'b1, `TCR_ADDR_CLK_FIFO, 32'h42);
        fifo_overflow <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("self_flush", 1, fifo_reset);
        fifo_overflow <= 1'b0;
        repeat (60) @(posedge pclk);
        chk("flush_end", 0, fifo_reset);
        $display("flush test done");
        tally_and_finish;
    end
endmodule
bind tcr_config_regs tcr_cfg_assertions #(.ADDR_W(ADDR_W)) i_tcr_cfg_assertions(.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_los_raw, .ref_freq_select, .aux_clock_on, .fifo_reset,
    .loss_of_signal_flag, .rx_parallel_data, .vcxo_lock_detect_on, .vcxo_locked);
